// ==== shared/isa_pkg.sv ====
// Constants, register map and engine states of the I2C status and own-address block.
package isa_pkg;

	// APB byte addresses of the registers.
	localparam logic [7:0] ISA_OFS_CTRL     = 8'h00;
	localparam logic [7:0] ISA_OFS_STATUS   = 8'h04;
	localparam logic [7:0] ISA_OFS_BUFFER   = 8'h08;
	localparam logic [7:0] ISA_OFS_OWN_LOW  = 8'h0c;
	localparam logic [7:0] ISA_OFS_OWN_HIGH = 8'h10;

	// Control register fields.
	localparam int ISA_CTRL_ON    = 0;
	localparam int ISA_CTRL_IRQ   = 1;
	localparam int ISA_CTRL_ACK   = 2;
	localparam int ISA_CTRL_GCALL = 3;
	localparam int ISA_CTRL_TEN   = 4;
	localparam logic [4:0] ISA_CTRL_RESET = 5'h00;

	// Status register fields.
	localparam int ISA_ST_TRA  = 5;
	localparam int ISA_ST_BUSY = 4;
	localparam int ISA_ST_BTF  = 3;
	localparam int ISA_ST_SLAVE_MATCH_FLAG = 2;

	// Own-address high register fields and reset value.
	localparam int ISA_OAH_FR_HI  = 7;
	localparam int ISA_OAH_FR_LO  = 6;
	localparam int ISA_OAH_ADD_HI = 2;
	localparam int ISA_OAH_ADD_LO = 1;
	localparam logic [7:0] ISA_OAH_MASK  = 8'hc6;
	localparam logic [7:0] ISA_OAH_RESET = 8'h40;
	localparam logic [7:0] ISA_OAL_RESET = 8'h00;

	// Address patterns seen on the bus.
	localparam logic [7:0] ISA_ADDR_NEVER = 8'h01;
	localparam logic [6:0] ISA_ADDR_GCALL = 7'h00;
	localparam logic [4:0] ISA_HDR10      = 5'h1e;
	localparam logic [3:0] ISA_LAST_BIT   = 4'h7;

	// Speed range codes.
	localparam logic [1:0] ISA_FR_SLOW = 2'b00;
	localparam logic [1:0] ISA_FR_MID  = 2'b01;

	// SDA hold after SCL falls, per speed range, and the clock rate.
	localparam int ISA_PCLK_HZ      = 20_000_000;
	localparam int ISA_HOLD_SLOW_NS = 300;
	localparam int ISA_HOLD_MID_NS  = 150;
	localparam int ISA_HOLD_SLOW_CYC =
		(ISA_HOLD_SLOW_NS * (ISA_PCLK_HZ / 1_000_000) + 999) / 1000;
	localparam int ISA_HOLD_MID_CYC =
		(ISA_HOLD_MID_NS * (ISA_PCLK_HZ / 1_000_000) + 999) / 1000;

	typedef enum logic [2:0] {
		ISA_IDLE, ISA_HDR, ISA_HDR2, ISA_RX, ISA_TX, ISA_ACK_OUT, ISA_ACK_IN, ISA_SKIP
	} isa_state_t;

	typedef enum logic [1:0] {ISA_K_ADDR, ISA_K_HDR, ISA_K_DATA} isa_kind_t;

endpackage

// ==== src/isa_top.sv ====
// I2C slave status flags, own-address matching and clock stretching behind an APB slave.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Busy set on start, cleared on stop.
// - Bus error clears busy flag.
// - Busy not tracked while interface disabled.
// - Byte done flag set after good byte.
// - Transmit: flag set after acknowledge clock.
// - Address byte: flag only after post-header event.
// - Transmit clear: status read, buffer write.
// - Receive: set after ack, clear status+buffer read.
// - SCL held low while byte done set.
// - Disabling interface clears byte done flag.
// - Match flag on own address or call.
// - Match flag cleared by status read, disable.
// - SCL held low while match flag set.
// - Seven-bit: bits 7:1 match, direction ignored.
// - Seven-bit address value 01h never answered.
// - Ten-bit: low register 7:0, high 2:1.
// - Own-address bits survive interface disable.
// - Speed range selects SDA hold delay.
module isa_top (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// I2C pins, open drain
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	// Event request
	output logic             irq
);
	import isa_pkg::*;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic [4:0]  ctrl_q;
	logic [7:0]  own_low_q;
	logic [7:0]  own_high_q;
	logic [7:0]  buf_q;
	logic        busy_q;
	logic        btf_q;
	logic        slave_match_flag_q;
	logic        tra_q;
	logic        status_seen_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        irq_q;
	logic        scl_oe_q;
	logic        sda_oe_q;
	logic        low_q;
	logic [1:0]  scl_sync_q;
	logic [1:0]  sda_sync_q;
	logic        scl_prev_q;
	logic        sda_prev_q;
	isa_state_t  st_q;
	isa_kind_t   kind_q;
	logic [3:0]  cnt_q;
	logic [7:0]  sh_q;
	logic [7:0]  tx_q;
	logic        ack_drv_q;
	logic        rw_q;
	logic        nack_q;
	logic        ten_hit_q;
	logic [3:0]  hold_q;
	logic        on;
	logic        scl_s;
	logic        sda_s;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_seen;
	logic        stop_seen;
	logic        bus_err;
	logic        setup;
	logic        acc_rd;
	logic        acc_wr;
	logic        rd_status;
	logic        buf_rd;
	logic        buf_wr;
	logic [7:0]  status_byte;
	logic [7:0]  byte_in;
	logic        hit7;
	logic        hit_gc;
	logic        hit_hdr;
	logic        hit_low10;
	logic        set_btf;
	logic        set_slave_match_flag;
	logic        rx_store;
	logic        sda_want;
	logic [3:0]  hold_cyc;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_sync_q <= 2'b11;
			sda_sync_q <= 2'b11;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], scl_i};
			sda_sync_q <= {sda_sync_q[0], sda_i};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end

	assign scl_s      = scl_sync_q[1];
	assign sda_s      = sda_sync_q[1];
	assign scl_rise   = scl_s & ~scl_prev_q;
	assign scl_fall   = ~scl_s & scl_prev_q;
	assign start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_seen  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	// A start or stop inside a byte is a misplaced condition.
	assign bus_err    = (start_seen | stop_seen) && st_q != ISA_IDLE && st_q != ISA_SKIP
		&& cnt_q != 4'h0;
	assign on         = ctrl_q[ISA_CTRL_ON];

	////////////////////////////////////////////////////////////////////////////////////////////
	// APB decode. Zero wait states: pready rises in the access cycle.
	assign setup     = psel & ~penable;
	assign acc_rd    = psel & penable & ~pwrite;
	assign acc_wr    = psel & penable & pwrite;
	assign rd_status = acc_rd && paddr == ISA_OFS_STATUS;
	assign buf_rd    = acc_rd && paddr == ISA_OFS_BUFFER;
	assign buf_wr    = acc_wr && paddr == ISA_OFS_BUFFER;

	always_comb begin
		status_byte              = 8'h00;
		status_byte[ISA_ST_TRA]  = tra_q;
		status_byte[ISA_ST_BUSY] = busy_q;
		status_byte[ISA_ST_BTF]  = btf_q;
		status_byte[ISA_ST_SLAVE_MATCH_FLAG] = slave_match_flag_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= 1'b0;
			if (setup) begin
				prdata_q <= 32'h0000_0000;
				if (paddr == ISA_OFS_CTRL) begin
					prdata_q[4:0] <= ctrl_q;
				end else if (paddr == ISA_OFS_STATUS) begin
					prdata_q[7:0] <= status_byte;
				end else if (paddr == ISA_OFS_BUFFER) begin
					prdata_q[7:0] <= buf_q;
				end else if (paddr == ISA_OFS_OWN_LOW) begin
					prdata_q[7:0] <= own_low_q;
				end else if (paddr == ISA_OFS_OWN_HIGH) begin
					prdata_q[7:0] <= own_high_q & ISA_OAH_MASK;
				end else begin
					pslverr_q <= 1'b1;
				end
			end
		end
	end

	// Configuration registers. Own-address bits are untouched by disabling.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q     <= ISA_CTRL_RESET;
			own_low_q  <= ISA_OAL_RESET;
			own_high_q <= ISA_OAH_RESET;
		end else if (acc_wr) begin
			if (paddr == ISA_OFS_CTRL) begin
				ctrl_q <= pwdata[4:0];
			end else if (paddr == ISA_OFS_OWN_LOW) begin
				own_low_q <= pwdata[7:0];
			end else if (paddr == ISA_OFS_OWN_HIGH) begin
				// Speed range is meant to be written while disabled; hardware accepts any time.
				own_high_q <= pwdata[7:0] & ISA_OAH_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Address matching on the byte just completed.
	assign byte_in   = sh_q;
	assign hit7      = ~ctrl_q[ISA_CTRL_TEN] && byte_in[7:1] == own_low_q[7:1]
		&& byte_in != ISA_ADDR_NEVER;
	assign hit_gc    = ctrl_q[ISA_CTRL_GCALL] && byte_in[7:1] == ISA_ADDR_GCALL && !byte_in[0];
	assign hit_hdr   = ctrl_q[ISA_CTRL_TEN] && byte_in[7:3] == ISA_HDR10
		&& byte_in[2:1] == own_high_q[ISA_OAH_ADD_HI:ISA_OAH_ADD_LO];
	assign hit_low10 = byte_in == own_low_q;

	// Speed range picks the SDA hold delay after SCL falls.
	always_comb begin
		if (own_high_q[ISA_OAH_FR_HI:ISA_OAH_FR_LO] == ISA_FR_SLOW) begin
			hold_cyc = 4'(ISA_HOLD_SLOW_CYC);
		end else begin
			hold_cyc = 4'(ISA_HOLD_MID_CYC);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Bus engine.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= ISA_IDLE;
			kind_q    <= ISA_K_ADDR;
			cnt_q     <= 4'h0;
			sh_q      <= 8'h00;
			tx_q      <= 8'h00;
			ack_drv_q <= 1'b0;
			rw_q      <= 1'b0;
			nack_q    <= 1'b0;
			ten_hit_q <= 1'b0;
		end else if (!on) begin
			st_q      <= ISA_IDLE;
			cnt_q     <= 4'h0;
			ack_drv_q <= 1'b0;
			ten_hit_q <= 1'b0;
		end else if (stop_seen) begin
			st_q      <= ISA_IDLE;
			cnt_q     <= 4'h0;
			ten_hit_q <= 1'b0;
		end else if (start_seen) begin
			st_q  <= ISA_HDR;
			cnt_q <= 4'h0;
		end else begin
			case (st_q)
				ISA_HDR, ISA_HDR2, ISA_RX: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == ISA_LAST_BIT + 4'h1) begin
						cnt_q <= 4'h0;
						if (st_q == ISA_RX) begin
							kind_q    <= ISA_K_DATA;
							ack_drv_q <= ctrl_q[ISA_CTRL_ACK];
							st_q      <= ISA_ACK_OUT;
						end else if (st_q == ISA_HDR2) begin
							st_q      <= hit_low10 ? ISA_ACK_OUT : ISA_SKIP;
							kind_q    <= ISA_K_ADDR;
							ack_drv_q <= hit_low10;
							ten_hit_q <= hit_low10;
						end else if (hit7 || hit_gc) begin
							kind_q    <= ISA_K_ADDR;
							rw_q      <= byte_in[0];
							ack_drv_q <= 1'b1;
							st_q      <= ISA_ACK_OUT;
						end else if (hit_hdr && !byte_in[0]) begin
							kind_q    <= ISA_K_HDR;
							rw_q      <= 1'b0;
							ack_drv_q <= 1'b1;
							st_q      <= ISA_ACK_OUT;
						end else if (hit_hdr && ten_hit_q) begin
							kind_q    <= ISA_K_ADDR;
							rw_q      <= 1'b1;
							ack_drv_q <= 1'b1;
							st_q      <= ISA_ACK_OUT;
						end else begin
							st_q <= ISA_SKIP;
						end
					end
				end
				ISA_ACK_OUT: begin
					if (scl_fall) begin
						ack_drv_q <= 1'b0;
						if (kind_q == ISA_K_HDR) begin
							st_q <= ISA_HDR2;
						end else if (kind_q == ISA_K_ADDR && rw_q) begin
							st_q <= ISA_TX;
						end else begin
							st_q <= ISA_RX;
						end
					end
				end
				ISA_TX: begin
					// While stretched the next byte is taken from the buffer.
					if (low_q) begin
						tx_q <= buf_q;
					end else if (scl_rise) begin
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall) begin
						tx_q <= {tx_q[6:0], 1'b0};
						if (cnt_q == ISA_LAST_BIT + 4'h1) begin
							cnt_q <= 4'h0;
							st_q  <= ISA_ACK_IN;
						end
					end
				end
				ISA_ACK_IN: begin
					if (scl_rise) begin
						nack_q <= sda_s;
					end else if (scl_fall) begin
						st_q <= nack_q ? ISA_SKIP : ISA_TX;
					end
				end
				default: begin
					cnt_q <= 4'h0;
				end
			endcase
		end
	end

	// Flag set events on the SCL fall that ends the ninth clock.
	assign set_btf  = on && scl_fall && !stop_seen && !start_seen
		&& ((st_q == ISA_ACK_OUT && kind_q == ISA_K_DATA)
		|| st_q == ISA_ACK_IN);
	// Address bytes raise the match flag only; the byte flag waits for later data.
	assign set_slave_match_flag = on && scl_fall && !stop_seen && !start_seen
		&& st_q == ISA_ACK_OUT && kind_q == ISA_K_ADDR;
	assign rx_store = set_btf && st_q == ISA_ACK_OUT;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Status flags. In the byte done and match flags the hardware set is written last so it wins over a clear; busy clears on stop over start.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
		end else if (on) begin
			if (stop_seen || bus_err) begin
				busy_q <= 1'b0;
			end else if (start_seen) begin
				busy_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_seen_q <= 1'b0;
		end else if (!on) begin
			status_seen_q <= 1'b0;
		end else if (rd_status) begin
			status_seen_q <= 1'b1;
		end else if (buf_rd || buf_wr) begin
			status_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			btf_q <= 1'b0;
			tra_q <= 1'b0;
		end else if (!on) begin
			btf_q <= 1'b0;
			tra_q <= 1'b0;
		end else begin
			if (status_seen_q && ((tra_q && buf_wr) || (!tra_q && buf_rd))) begin
				btf_q <= 1'b0;
				tra_q <= 1'b0;
			end
			if (stop_seen) begin
				tra_q <= 1'b0;
			end
			if (set_btf) begin
				btf_q <= 1'b1;
				tra_q <= st_q == ISA_ACK_IN;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slave_match_flag_q <= 1'b0;
		end else if (!on) begin
			slave_match_flag_q <= 1'b0;
		end else begin
			if (rd_status) begin
				slave_match_flag_q <= 1'b0;
			end
			if (set_slave_match_flag) begin
				slave_match_flag_q <= 1'b1;
			end
		end
	end

	// Byte buffer: software writes transmit data, the engine stores received bytes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_q <= 8'h00;
		end else if (rx_store) begin
			buf_q <= sh_q;
		end else if (buf_wr) begin
			buf_q <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Pin drivers. SCL is stretched from the same edge that raises a flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_q    <= 1'b0;
			scl_oe_q <= 1'b0;
		end else begin
			low_q    <= (btf_q | slave_match_flag_q | set_btf | set_slave_match_flag) & on;
			scl_oe_q <= (btf_q | slave_match_flag_q | set_btf | set_slave_match_flag) & on;
		end
	end

	assign sda_want = on && ((st_q == ISA_ACK_OUT && ack_drv_q) || (st_q == ISA_TX && !tx_q[7]));

	// SDA changes only once the hold delay after an SCL fall has run out.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q   <= 4'h0;
			sda_oe_q <= 1'b0;
		end else if (scl_fall) begin
			hold_q <= hold_cyc;
		end else if (hold_q != 4'h0) begin
			hold_q <= hold_q - 4'h1;
		end else if (!scl_s || !on || st_q == ISA_IDLE || st_q == ISA_SKIP) begin
			sda_oe_q <= sda_want;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= ctrl_q[ISA_CTRL_IRQ] & (btf_q | slave_match_flag_q);
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign scl_o   = 1'b0;
	assign scl_oe  = scl_oe_q;
	assign sda_o   = 1'b0;
	assign sda_oe  = sda_oe_q;
	assign irq     = irq_q;

endmodule // isa_top

`default_nettype wire

// ==== bench/isa_chk_sva.sv ====
// Port assertions for the I2C status and own-address block.
`timescale 1ns/100ps
`default_nettype none
module isa_chk
	import isa_pkg::*;
(
	// APB slave
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// I2C pins
	input wire logic        scl_i,
	input wire logic        scl_o,
	input wire logic        scl_oe,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe,
	// Event request
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic mapped;
	logic st_rd;
	assign acc = psel & penable;
	assign mapped = paddr inside {ISA_OFS_CTRL, ISA_OFS_STATUS, ISA_OFS_BUFFER,
		ISA_OFS_OWN_LOW, ISA_OFS_OWN_HIGH};
	assign st_rd = acc & !pwrite & (paddr == ISA_OFS_STATUS);
	////////////////////////////////////////////////////////////////////////////////
	AST_READY: assert property (acc |-> pready)
		else $error("access cycle without ready");
	AST_NO_EARLY: assert property (psel && !penable |-> !pready)
		else $error("ready in setup cycle");
	AST_UNMAPPED: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_MAPPED: assert property (acc && mapped |-> !pslverr && prdata[31:8] == 24'h0)
		else $error("mapped access refused or upper bits set");
	AST_OAH_RSV: assert property (
		acc && !pwrite && paddr == ISA_OFS_OWN_HIGH |-> (prdata & ~32'hc6) == 32'h0)
		else $error("reserved high address bits not zero");
	AST_STRETCH: assert property (st_rd && (prdata[3] || prdata[2]) |-> ##[0:1] scl_oe)
		else $error("flag set without clock stretch");
	AST_IRQ_FLAG: assert property ($rose(irq) |-> ##[0:1] scl_oe)
		else $error("event request without a pending flag");
	AST_OPEN_DRAIN: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("pin driven high");
	AST_SDA_LOW: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data line moved while clock high");
	AST_SDA_HOLD: assert property ($fell(scl_i) |=> $stable(sda_oe)[*3])
		else $error("data line moved inside hold delay");
endmodule // isa_chk

bind isa_top isa_chk isa_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
`default_nettype wire

// ==== bench/isa_master.sv ====
// Behavioural I2C bus master that writes bytes to the block.
`timescale 1ns/100ps
`default_nettype none
module isa_master (
	// Bus levels
	input  wire logic scl,
	input  wire logic sda,
	// Pull-downs, high pulls the line low
	output var logic  scl_pull,
	output var logic  sda_pull
);
	// The low phase is long because the slave answers only after sync and hold.
	localparam int HALF = 200;
	int stalls;
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
		stalls = 0;
	end
	task automatic rise();
		int i;
		scl_pull = 1'b0;
		for (i = 0; i < 4000 && scl !== 1'b1; i++) begin
			#10;
		end
		if (i == 4000) begin
			stalls++;
		end
	endtask
	task automatic bit_io(input logic b, output logic r);
		#100;
		sda_pull = !b;
		#(3 * HALF - 100);
		rise();
		#(HALF / 2);
		r = sda;
		#(HALF / 2);
		scl_pull = 1'b1;
	endtask
	task automatic start();
		sda_pull = 1'b1;
		#HALF;
		scl_pull = 1'b1;
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, ack);
		#HALF;
	endtask
	task automatic stop();
		#100;
		sda_pull = 1'b1;
		#(3 * HALF - 100);
		rise();
		#HALF;
		sda_pull = 1'b0;
		#HALF;
	endtask
endmodule // isa_master
`default_nettype wire

// ==== bench/isa_top_bench.sv ====
// Self-checking bench for the I2C status and own-address block.
`timescale 1ns/100ps
`default_nettype none
module isa_top_bench;
	import isa_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        scl_o;
	logic        scl_oe;
	logic        sda_o;
	logic        sda_oe;
	logic        irq;
	logic        m_scl;
	logic        m_sda;
	wire         scl_w;
	wire         sda_w;
	int          n_fail;
	int          checked;
	// Open drain with pull-ups: the line is low while anyone pulls it.
	assign scl_w = !(scl_oe | m_scl);
	assign sda_w = !(sda_oe | m_sda);
	isa_top isa_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
	isa_master isa_master_inst (.scl(scl_w), .sda(sda_w), .scl_pull(m_scl), .sda_pull(m_sda));
	always #25 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (n_fail == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Request stands until the rising edge at which ready is sampled high.
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin
			n_fail++;
			end_sim();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask
	task automatic m_start();
		@(negedge pclk);
		isa_master_inst.start();
	endtask
	task automatic m_send(input logic [7:0] d, output logic a);
		@(negedge pclk);
		isa_master_inst.send(d, a);
	endtask
	task automatic m_stop();
		@(negedge pclk);
		isa_master_inst.stop();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		rd(ISA_OFS_OWN_HIGH, r);
		chk("own_id_high reset", r, 32'h40);
		rd(ISA_OFS_OWN_LOW, r);
		chk("own_id_low reset", r, 32'h0);
		wr(ISA_OFS_OWN_HIGH, 32'hffffffff);
		rd(ISA_OFS_OWN_HIGH, r);
		chk("own_id_high mask", r, 32'hc6);
		wr(ISA_OFS_OWN_HIGH, 32'h40);
		apb(1'b0, 8'h14, 32'h0, r, e);
		chk("unmapped error", 32'(e), 32'h1);
		chk("unmapped data", r, 32'h0);
	endtask
	task automatic t_match();
		logic [31:0] r;
		logic a;
		wr(ISA_OFS_OWN_LOW, 32'h5a);
		wr(ISA_OFS_CTRL, 32'h07);
		m_start();
		m_send(8'h5a, a);
		chk("address ack", 32'(a), 32'h0);
		chk("irq on match", 32'(irq), 32'h1);
		chk("stretch on match", 32'(scl_oe), 32'h1);
		rd(ISA_OFS_STATUS, r);
		chk("status matched", r, 32'h14);
		rd(ISA_OFS_STATUS, r);
		chk("match cleared", r, 32'h10);
		m_send(8'hc3, a);
		chk("data ack", 32'(a), 32'h0);
		chk("stretch on byte", 32'(scl_oe), 32'h1);
		rd(ISA_OFS_STATUS, r);
		chk("status byte done", r, 32'h18);
		rd(ISA_OFS_BUFFER, r);
		chk("received byte", r, 32'hc3);
		rd(ISA_OFS_STATUS, r);
		chk("byte done cleared", r, 32'h10);
		m_stop();
		rd(ISA_OFS_STATUS, r);
		chk("busy after stop", r, 32'h0);
	endtask
	task automatic t_never();
		logic [31:0] r;
		logic a;
		// Own address zero would match 01h on bits 7:1 if not excluded.
		wr(ISA_OFS_OWN_LOW, 32'h0);
		m_start();
		m_send(8'h01, a);
		chk("01h not acked", 32'(a), 32'h1);
		rd(ISA_OFS_STATUS, r);
		chk("01h no match", r, 32'h10);
		m_stop();
	endtask
	task automatic t_off();
		logic [31:0] r;
		logic a;
		wr(ISA_OFS_OWN_LOW, 32'h5a);
		m_start();
		m_send(8'h5b, a);
		chk("read bit ignored", 32'(a), 32'h0);
		// The match flag stretches SCL; the status read releases it before the stop.
		rd(ISA_OFS_STATUS, r);
		chk("read match status", r, 32'h14);
		m_stop();
		wr(ISA_OFS_OWN_HIGH, 32'h40);
		rd(ISA_OFS_STATUS, r);
		m_start();
		m_send(8'h5a, a);
		rd(ISA_OFS_STATUS, r);
		m_send(8'h3c, a);
		wr(ISA_OFS_CTRL, 32'h0);
		rd(ISA_OFS_STATUS, r);
		chk("flags after disable", r, 32'h10);
		chk("stretch after disable", 32'(scl_oe), 32'h0);
		rd(ISA_OFS_OWN_LOW, r);
		chk("own_id_low kept", r, 32'h5a);
		m_stop();
		wr(ISA_OFS_CTRL, 32'h07);
		rd(ISA_OFS_STATUS, r);
		chk("stale busy", r, 32'h10);
		m_start();
		m_stop();
		rd(ISA_OFS_STATUS, r);
		chk("busy cleared", r, 32'h0);
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		n_fail = 0;
		checked = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_match();
		t_never();
		t_off();
		chk("bus stalls", 32'(isa_master_inst.stalls), 32'h0);
		end_sim();
	end
endmodule // isa_top_bench
`default_nettype wire
